// >>> pkg/bip_params.svh
/*
 * Constants of the bit-level two-wire port: register offsets, bit positions,
 * reset values and timing counts.
 * Assumes a 100 MHz pclk and an APB slave with one 32-bit word per register.
 */
`ifndef BIP_PARAMS_SVH
`define BIP_PARAMS_SVH

`define BIP_OFF_CONTROL     8'h00
`define BIP_OFF_CONFIG      8'h04
`define BIP_OFF_DATA        8'h08
`define BIP_OFF_STATUS      8'h0c
`define BIP_OFF_IRQ         8'h10

`define BIP_CW_CXA          7
`define BIP_CW_IDLE         6
`define BIP_CW_CDR          5
`define BIP_CW_CLEAR_ARBITRATION_LOST         4
`define BIP_CW_CLEAR_START_SEEN         3
`define BIP_CW_CLEAR_STOP_SEEN         2
`define BIP_CW_SEND_REPEATED_START         1
`define BIP_CW_SEND_STOP_REQUEST         0

`define BIP_CF_SLAVE_EN     7
`define BIP_CF_MASTER_REQ   6
`define BIP_CF_CLEAR_WDOG   5
`define BIP_CF_WDOG_RUN     4

`define BIP_DATA_BIT        7

`define BIP_IRQ_BUS_EN      0
`define BIP_IRQ_WDOG_EN     1
`define BIP_IRQ_WDOG_FLAG   2

`define BIP_CONFIG_RST      8'h00
`define BIP_IRQ_RST         2'h0

`define BIP_BUS_VECTOR      8'h23
`define BIP_WDOG_VECTOR     8'h1b

`define BIP_CLK_NS          10
`define BIP_HALF_NS         5000
`define BIP_HALF_CYCLES     ((`BIP_HALF_NS + `BIP_CLK_NS - 1) / `BIP_CLK_NS)
`define BIP_WDOG_CYCLES     1024

`endif

// >>> pkg/bip_pkg.sv
/*
 * Types of the bit-level two-wire port.
 * Assumes bip_params.svh supplies the numeric constants.
 */
`default_nettype none
package bip_pkg;

    typedef enum logic [3:0] {
        BIP_ST_IDLE      = 4'h0,
        BIP_ST_START     = 4'h1,
        BIP_ST_LOW       = 4'h2,
        BIP_ST_HIGH_WAIT = 4'h3,
        BIP_ST_HIGH      = 4'h4,
        BIP_ST_RS_REL    = 4'h5,
        BIP_ST_RS_HIGH   = 4'h6,
        BIP_ST_STOP_LOW  = 4'h7,
        BIP_ST_STOP_HIGH = 4'h8
    } bip_state_t;

    typedef struct packed {
        logic received_bit;
        logic attention_flag;
        logic bit_ready_flag;
        logic arbitration_lost_flag;
        logic start_seen_flag;
        logic stop_seen_flag;
        logic master;
        logic unused;
    } bip_ctrl_view_t;

    typedef struct packed {
        logic idle;
        logic transmit_buffer_state;
        logic transmitter_on;
        logic making_start;
        logic making_stop;
        logic making_repeated_start;
        logic stop_pending;
        logic unused;
    } bip_status_t;

    typedef struct packed {
        logic slave_function_enable;
        logic bus_ownership_request;
        logic bus_watchdog_run;
        logic divider_select_high;
        logic divider_select_low;
    } bip_config_t;

endpackage
`default_nettype wire

// >>> hw/bip_port.sv
/*
 * Bit-level two-wire bus port with bus watchdog, reached over APB.
 * Assumes scl/sda pins are open-drain wires resolved outside; pins are async.
 */
// Decided for this implementation: register access over APB and the register offsets.
`include "bip_params.svh"
`default_nettype none
module bip_port
    import bip_pkg::*;
#(
    parameter int WDOG_CYCLES = `BIP_WDOG_CYCLES
) (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Bus pins
    input  wire logic        scl_in,
    output logic             scl_out,
    output logic             scl_oe,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe,
    // Interrupt requests
    output logic             bus_irq,
    output logic             watchdog_irq,
    output logic      [7:0]  irq_vector
);

    localparam logic [15:0] HALF_BASE = 16'(`BIP_HALF_CYCLES);

    function automatic logic [15:0] half_for(input logic [1:0] sel);
        half_for = 16'(HALF_BASE * ({14'h0, sel} + 16'h1));
    endfunction

    // Pin synchronisers
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic       scl_prev;
    logic       sda_prev;

    // Register state
    bip_config_t cfg;
    logic        bus_irq_enable;
    logic        watchdog_irq_enable;
    logic        watchdog_flag;
    logic        received_bit;
    logic        bit_ready_flag;
    logic        arbitration_lost_flag;
    logic        start_seen_flag;
    logic        stop_seen_flag;
    logic        master;
    logic        idle;
    logic        transmitter_on;
    logic        transmit_bit;
    logic        tx_bit_out;
    logic        frame_active;
    logic        rstart_pending;
    logic        stop_pending;
    logic [15:0] wdog_cnt;
    logic [15:0] cnt;
    bip_state_t  state;
    bip_state_t  next_state;
    logic        next_cnt_clr;

    wire scl_s = scl_sync[1];
    wire sda_s = sda_sync[1];
    wire scl_rise = scl_s & ~scl_prev;
    wire scl_fall = ~scl_s & scl_prev;
    wire scl_edge = scl_rise | scl_fall;
    wire start_det = scl_s & scl_prev & sda_prev & ~sda_s;
    wire stop_det = scl_s & scl_prev & ~sda_prev & sda_s;

    // APB decode
    wire apb_fire = psel & penable & pready;
    wire wr_fire = apb_fire & pwrite;
    wire rd_fire = apb_fire & ~pwrite;
    wire sel_ctrl = (paddr == `BIP_OFF_CONTROL);
    wire sel_cfg = (paddr == `BIP_OFF_CONFIG);
    wire sel_data = (paddr == `BIP_OFF_DATA);
    wire sel_stat = (paddr == `BIP_OFF_STATUS);
    wire sel_irq = (paddr == `BIP_OFF_IRQ);
    wire addr_hit = sel_ctrl | sel_cfg | sel_data | sel_stat | sel_irq;
    wire ctrl_wr = wr_fire & sel_ctrl;
    wire data_wr = wr_fire & sel_data;
    wire data_rd = rd_fire & sel_data;
    wire data_any = data_wr | data_rd;

    wire wr_cxa = ctrl_wr & pwdata[`BIP_CW_CXA];
    wire wr_idle = ctrl_wr & pwdata[`BIP_CW_IDLE];
    wire wr_cdr = ctrl_wr & pwdata[`BIP_CW_CDR];
    wire wr_clear_arbitration_lost = ctrl_wr & pwdata[`BIP_CW_CLEAR_ARBITRATION_LOST];
    wire wr_clear_start_seen = ctrl_wr & pwdata[`BIP_CW_CLEAR_START_SEEN];
    wire wr_clear_stop_seen = ctrl_wr & pwdata[`BIP_CW_CLEAR_STOP_SEEN];
    wire wr_send_repeated_start = ctrl_wr & pwdata[`BIP_CW_SEND_REPEATED_START];
    wire wr_send_stop_request = ctrl_wr & pwdata[`BIP_CW_SEND_STOP_REQUEST];
    wire wr_clr_wdog = wr_fire & sel_cfg & pwdata[`BIP_CF_CLEAR_WDOG];

    // Port behaviour
    wire port_on = cfg.slave_function_enable | cfg.bus_ownership_request;
    wire idle_slave = idle & ~master;
    wire [15:0] half = half_for({cfg.divider_select_high, cfg.divider_select_low});
    wire half_done = (cnt >= half - 16'h1);
    wire wdog_hit = port_on & cfg.bus_watchdog_run & frame_active
                    & (wdog_cnt == 16'(WDOG_CYCLES - 1));
    wire seq_state = (state == BIP_ST_START) | (state == BIP_ST_RS_REL) | (state == BIP_ST_RS_HIGH)
                     | (state == BIP_ST_STOP_LOW) | (state == BIP_ST_STOP_HIGH);
    wire arb_lost = port_on & scl_rise & transmitter_on & tx_bit_out & ~sda_s & ~seq_state;
    wire attention = bit_ready_flag | arbitration_lost_flag | start_seen_flag | stop_seen_flag;

    // Master engine, slave clock stretch and data bit drive decisions
    wire m_scl_low = (state == BIP_ST_LOW) | (state == BIP_ST_RS_REL) | (state == BIP_ST_STOP_LOW);
    wire m_sda_low = (state == BIP_ST_START) | (state == BIP_ST_STOP_LOW) | (state == BIP_ST_STOP_HIGH);
    wire m_sda_rel = (state == BIP_ST_RS_REL) | (state == BIP_ST_RS_HIGH);
    wire slave_stretch = port_on & ~idle_slave & bit_ready_flag & ~scl_s;
    wire next_scl_oe = port_on & (m_scl_low | slave_stretch);
    wire data_drive = transmitter_on & ~tx_bit_out & ~m_sda_rel;
    wire next_sda_oe = port_on & (m_sda_low | data_drive);

    // Register read views
    bip_ctrl_view_t ctrl_view;
    bip_status_t    stat_view;
    assign ctrl_view = '{received_bit, attention, bit_ready_flag, arbitration_lost_flag,
                         start_seen_flag, stop_seen_flag, master, 1'b0};
    assign stat_view = '{idle, transmit_bit, transmitter_on, state == BIP_ST_START,
                         (state == BIP_ST_STOP_LOW) | (state == BIP_ST_STOP_HIGH),
                         (state == BIP_ST_RS_REL) | (state == BIP_ST_RS_HIGH),
                         stop_pending, 1'b0};
    wire [7:0] cfg_view = {cfg.slave_function_enable, cfg.bus_ownership_request, 1'b0,
                           cfg.bus_watchdog_run, 2'b00, cfg.divider_select_high, cfg.divider_select_low};
    wire [7:0] data_view = {received_bit, 7'h00};
    wire [7:0] irq_view = {5'h00, watchdog_flag, watchdog_irq_enable, bus_irq_enable};
    wire [7:0] rd_mux = sel_ctrl ? ctrl_view : sel_cfg ? cfg_view : sel_data ? data_view
                        : sel_stat ? stat_view : sel_irq ? irq_view : 8'h00;

    // Master clock engine: sequencing of start, bits, repeated start, stop
    always_comb begin
        next_state = state;
        next_cnt_clr = 1'b0;
        case (state)
            BIP_ST_IDLE: begin
                if (cfg.bus_ownership_request & ~frame_active & scl_s & sda_s) begin
                    next_state = BIP_ST_START;
                    next_cnt_clr = 1'b1;
                end
            end
            BIP_ST_START: begin
                if (half_done) begin
                    next_state = BIP_ST_LOW;
                    next_cnt_clr = 1'b1;
                end
            end
            BIP_ST_LOW: begin
                // Bit handshake: clock stays low until software services the bit
                if (half_done & ~bit_ready_flag) begin
                    next_cnt_clr = 1'b1;
                    if (stop_pending) begin
                        next_state = BIP_ST_STOP_LOW;
                    end else if (rstart_pending) begin
                        next_state = BIP_ST_RS_REL;
                    end else begin
                        next_state = BIP_ST_HIGH_WAIT;
                    end
                end
            end
            BIP_ST_HIGH_WAIT: begin
                if (scl_s) begin
                    next_state = BIP_ST_HIGH;
                    next_cnt_clr = 1'b1;
                end
            end
            BIP_ST_HIGH: begin
                if (scl_fall | half_done) begin
                    next_state = BIP_ST_LOW;
                    next_cnt_clr = 1'b1;
                end
            end
            BIP_ST_RS_REL: begin
                if (half_done) begin
                    next_state = BIP_ST_RS_HIGH;
                    next_cnt_clr = 1'b1;
                end
            end
            BIP_ST_RS_HIGH: begin
                if (~scl_s) begin
                    next_cnt_clr = 1'b1;
                end else if (half_done) begin
                    next_state = BIP_ST_START;
                    next_cnt_clr = 1'b1;
                end
            end
            BIP_ST_STOP_LOW: begin
                if (half_done) begin
                    next_state = BIP_ST_STOP_HIGH;
                    next_cnt_clr = 1'b1;
                end
            end
            BIP_ST_STOP_HIGH: begin
                if (~scl_s) begin
                    next_cnt_clr = 1'b1;
                end else if (half_done) begin
                    next_state = BIP_ST_IDLE;
                    next_cnt_clr = 1'b1;
                end
            end
            default: begin
                next_state = BIP_ST_IDLE;
                next_cnt_clr = 1'b1;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scl_sync <= 2'b11;
            sda_sync <= 2'b11;
            scl_prev <= 1'b1;
            sda_prev <= 1'b1;
        end else begin
            scl_sync <= {scl_sync[0], scl_in};
            sda_sync <= {sda_sync[0], sda_in};
            scl_prev <= scl_s;
            sda_prev <= sda_s;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= BIP_ST_IDLE;
            cnt <= 16'h0;
        end else if (wdog_hit | arb_lost | ~cfg.bus_ownership_request & (state == BIP_ST_IDLE)) begin
            state <= BIP_ST_IDLE;
            cnt <= 16'h0;
        end else begin
            state <= next_state;
            cnt <= next_cnt_clr ? 16'h0 : cnt + 16'h1;
        end
    end

    // Bus watchdog
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdog_cnt <= 16'h0;
        end else if (~frame_active | scl_edge | wdog_hit | ~cfg.bus_watchdog_run) begin
            wdog_cnt <= 16'h0;
        end else begin
            wdog_cnt <= wdog_cnt + 16'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frame_active <= 1'b0;
        end else if (wdog_hit | stop_det | ~port_on) begin
            frame_active <= 1'b0;
        end else if (start_det) begin
            frame_active <= 1'b1;
        end
    end

    // Flags: hardware set wins over a software clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bit_ready_flag <= 1'b0;
            arbitration_lost_flag <= 1'b0;
            start_seen_flag <= 1'b0;
            stop_seen_flag <= 1'b0;
            received_bit <= 1'b0;
            watchdog_flag <= 1'b0;
        end else begin
            if (scl_rise & port_on) begin
                received_bit <= sda_s;
            end
            if (scl_rise & port_on & ~idle_slave & ~wdog_hit) begin
                bit_ready_flag <= 1'b1;
            end else if (data_any | wr_cdr | wdog_hit) begin
                bit_ready_flag <= 1'b0;
            end
            if (arb_lost) begin
                arbitration_lost_flag <= 1'b1;
            end else if (wr_clear_arbitration_lost) begin
                arbitration_lost_flag <= 1'b0;
            end
            if (start_det & port_on) begin
                start_seen_flag <= 1'b1;
            end else if (wr_clear_start_seen) begin
                start_seen_flag <= 1'b0;
            end
            if (stop_det & port_on & ~idle_slave) begin
                stop_seen_flag <= 1'b1;
            end else if (wr_clear_stop_seen) begin
                stop_seen_flag <= 1'b0;
            end
            if (wdog_hit) begin
                watchdog_flag <= 1'b1;
            end else if (wr_clr_wdog) begin
                watchdog_flag <= 1'b0;
            end
        end
    end

    // Transmitter, mode and pending requests
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            transmitter_on <= 1'b0;
            transmit_bit <= 1'b1;
            tx_bit_out <= 1'b1;
            master <= 1'b0;
            idle <= 1'b1;
            rstart_pending <= 1'b0;
            stop_pending <= 1'b0;
        end else begin
            if (data_wr) begin
                transmit_bit <= pwdata[`BIP_DATA_BIT];
            end
            if (~scl_s) begin
                tx_bit_out <= transmit_bit;
            end
            if (data_wr | wr_send_repeated_start | wr_send_stop_request) begin
                transmitter_on <= 1'b1;
            end else if (arb_lost | wdog_hit | wr_cxa | data_rd) begin
                transmitter_on <= 1'b0;
            end
            if (wdog_hit | arb_lost | stop_det) begin
                master <= 1'b0;
            end else if (state == BIP_ST_IDLE & next_state == BIP_ST_START) begin
                master <= 1'b1;
            end
            if (wr_idle | wdog_hit) begin
                idle <= 1'b1;
            end else if (start_det & port_on) begin
                idle <= 1'b0;
            end
            if (wr_send_repeated_start) begin
                rstart_pending <= 1'b1;
            end else if ((state == BIP_ST_RS_REL) | wdog_hit | arb_lost) begin
                rstart_pending <= 1'b0;
            end
            if (wr_send_stop_request) begin
                stop_pending <= 1'b1;
            end else if ((state == BIP_ST_STOP_LOW) | wdog_hit | arb_lost) begin
                stop_pending <= 1'b0;
            end
        end
    end

    // Configuration, interrupt enables, pins and APB answer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg <= bip_config_t'(5'h00);
            bus_irq_enable <= 1'b0;
            watchdog_irq_enable <= 1'b0;
            pready <= 1'b0;
            prdata <= 32'h0;
            pslverr <= 1'b0;
            scl_oe <= 1'b0;
            sda_oe <= 1'b0;
            scl_out <= 1'b0;
            sda_out <= 1'b0;
            bus_irq <= 1'b0;
            watchdog_irq <= 1'b0;
            irq_vector <= 8'h00;
        end else begin
            if (wr_fire & sel_cfg) begin
                cfg <= '{pwdata[`BIP_CF_SLAVE_EN], pwdata[`BIP_CF_MASTER_REQ],
                         pwdata[`BIP_CF_WDOG_RUN], pwdata[1], pwdata[0]};
            end
            if (wr_fire & sel_irq) begin
                bus_irq_enable <= pwdata[`BIP_IRQ_BUS_EN];
                watchdog_irq_enable <= pwdata[`BIP_IRQ_WDOG_EN];
            end
            pready <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & ~addr_hit;
            if (psel & penable & ~pready) begin
                prdata <= {24'h0, rd_mux};
            end
            scl_oe <= next_scl_oe;
            sda_oe <= next_sda_oe;
            scl_out <= 1'b0;
            sda_out <= 1'b0;
            bus_irq <= attention & bus_irq_enable;
            watchdog_irq <= watchdog_flag & watchdog_irq_enable;
            irq_vector <= (watchdog_flag & watchdog_irq_enable) ? `BIP_WDOG_VECTOR
                          : (attention & bus_irq_enable) ? `BIP_BUS_VECTOR : 8'h00;
        end
    end

    AST_SDA_ONLY_WHEN_TX: assert property (@(posedge pclk) disable iff (!presetn)
        sda_oe && !$past(m_sda_low) |-> $past(transmitter_on))
        else $error("data line pulled low without transmitter on");

    AST_DATA_WRITE_SETS_TX: assert property (@(posedge pclk) disable iff (!presetn)
        data_wr |=> transmitter_on)
        else $error("data write did not set transmitter on");

    AST_ARB_CLEARS_TX: assert property (@(posedge pclk) disable iff (!presetn)
        arb_lost && !(data_wr || wr_send_repeated_start || wr_send_stop_request) |=> !transmitter_on && arbitration_lost_flag)
        else $error("arbitration loss did not clear transmitter");

    AST_ARB_NEEDS_TX: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(arbitration_lost_flag) |-> $past(transmitter_on))
        else $error("arbitration loss set while not transmitting");

    AST_CXA_CLEARS_TX: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_cxa || data_rd) && !(data_wr || wr_send_repeated_start || wr_send_stop_request) |=> !transmitter_on)
        else $error("transmitter on not cleared");

    AST_READY_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
        (data_any || wr_cdr) && !scl_rise |=> !bit_ready_flag)
        else $error("bit ready flag not cleared");

    AST_CTRL_READ_KEEPS_READY: assert property (@(posedge pclk) disable iff (!presetn)
        rd_fire && sel_ctrl && bit_ready_flag && !wdog_hit |=> bit_ready_flag)
        else $error("control read cleared bit ready");

    AST_IRQ_FOLLOWS_ATTENTION: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 bus_irq == $past(attention && bus_irq_enable))
        else $error("bus interrupt not equal to gated attention");

    AST_WDOG_OUT_OF_FRAME: assert property (@(posedge pclk) disable iff (!presetn)
        !frame_active |=> wdog_cnt == 16'h0)
        else $error("watchdog counted outside a frame");

    AST_WDOG_RELEASES_CLOCK: assert property (@(posedge pclk) disable iff (!presetn)
        wdog_hit |=> state == BIP_ST_IDLE && !transmitter_on ##1 !scl_oe || bit_ready_flag)
        else $error("watchdog did not reset the port");

    AST_DATA_LOW_BITS_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
        rd_fire && sel_data |-> prdata[6:0] == 7'h00)
        else $error("data register low bits not zero");

endmodule
`default_nettype wire

// >>> tb/bip_bus_partner.sv
/*
 * Far side of the two-wire port: a behavioural master/slave that frames bits.
 * Assumes pull-ups on both lines; the bench calls its tasks, half period 80 ns.
 */
`default_nettype none
module bip_bus_partner (
    // Device pin enables
    input  wire logic scl_oe,
    input  wire logic sda_oe,
    // Resolved lines
    output logic      scl_line,
    output logic      sda_line
);
    timeunit 1ns;
    timeprecision 1ps;
    logic pull_scl = 1'b0;
    logic pull_sda = 1'b0;
    // Wired-AND lines; a released line rises to the pull-up
    assign scl_line = ~(scl_oe | pull_scl);
    assign sda_line = ~(sda_oe | pull_sda);
    task automatic frame_start;
        #3;
        pull_sda = 1'b1;
        #80;
        pull_scl = 1'b1;
        #80;
    endtask
    task automatic clock_bit(input logic v);
        #3;
        pull_sda = ~v;
        #80;
        pull_scl = 1'b0;
        #80;
    endtask
    // Holds the clock low as a slow slave would
    task automatic clock_low;
        #3;
        pull_scl = 1'b1;
        #80;
    endtask
endmodule
`default_nettype wire

// >>> tb/bip_port_bench.sv
/*
 * Self-checking bench of the two-wire port: registers, a slave frame, watchdog.
 * Assumes bip_pkg and bip_port are compiled first and bip_bus_partner drives the lines.
 */
`default_nettype none
module bip_port_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic        pready, pslverr, last_err, scl_oe, sda_oe, scl_line, sda_line, bus_irq, watchdog_irq;
    logic        scl_out, sda_out;
    logic [7:0]  irq_vector;
    int          err_total = 0;
    int          tests_run = 0;
    always #5 pclk = ~pclk;
    bip_port #(.WDOG_CYCLES(128)) i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_in(scl_line),
        .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .bus_irq(bus_irq),
        .watchdog_irq(watchdog_irq), .irq_vector(irq_vector));
    bip_bus_partner i_far (.scl_oe(scl_oe), .sda_oe(sda_oe), .scl_line(scl_line), .sda_line(sda_line));
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    // Whole-byte register access, held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20)
            err_total++;
        rd = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic t_regs;
        apb(1'b0, 8'h0c, 8'h00);
        chk(rd, 32'hc0);
        apb(1'b0, 8'h08, 8'h00);
        chk(rd & 32'h7f, 32'h0);
        apb(1'b0, 8'h10, 8'h00);
        chk(rd, 32'h0);
        apb(1'b0, 8'h14, 8'h00);
        chk(32'(last_err), 32'h1);
    endtask
    task automatic t_xmit;
        apb(1'b1, 8'h08, 8'h00);
        apb(1'b0, 8'h0c, 8'h00);
        chk(rd, 32'ha0);
        apb(1'b1, 8'h00, 8'h80);
        apb(1'b0, 8'h0c, 8'h00);
        chk(rd, 32'h80);
        apb(1'b1, 8'h08, 8'h80);
        apb(1'b0, 8'h08, 8'h00);
        apb(1'b0, 8'h0c, 8'h00);
        chk(rd, 32'hc0);
    endtask
    task automatic t_frame;
        apb(1'b1, 8'h04, 8'h90);
        apb(1'b1, 8'h10, 8'h03);
        i_far.frame_start();
        apb(1'b0, 8'h00, 8'h00);
        chk(rd & 32'h48, 32'h48);
        chk(32'({bus_irq, irq_vector}), 32'h123);
        apb(1'b1, 8'h00, 8'h08);
        cyc(3);
        chk(32'(bus_irq), 32'h0);
        i_far.clock_bit(1'b1);
        apb(1'b0, 8'h00, 8'h00);
        chk(rd & 32'ha0, 32'ha0);
        i_far.clock_low();
        cyc(4);
        chk(32'(scl_oe), 32'h1);
        apb(1'b0, 8'h00, 8'h00);
        chk(rd & 32'h20, 32'h20);
        apb(1'b0, 8'h08, 8'h00);
        chk(rd, 32'h80);
        cyc(3);
        chk(32'(scl_oe), 32'h0);
        // Clock is held low by the far side: a zero bit must pull data low
        apb(1'b1, 8'h08, 8'h00);
        cyc(3);
        chk(32'(sda_oe), 32'h1);
        chk(32'({scl_out, sda_out}), 32'h0);
        apb(1'b1, 8'h00, 8'h80);
        cyc(3);
        chk(32'(sda_oe), 32'h0);
    endtask
    task automatic t_wdog;
        int n;
        n = 0;
        while (watchdog_irq !== 1'b1 && n < 300) begin
            @(posedge pclk);
            n++;
        end
        chk(32'(n > 25), 32'h1);
        chk(32'({watchdog_irq, irq_vector}), 32'h11b);
        chk(32'(scl_oe), 32'h0);
        apb(1'b0, 8'h0c, 8'h00);
        chk(rd & 32'he0, 32'h80);
        apb(1'b1, 8'h04, 8'hb0);
        cyc(2);
        chk(32'(watchdog_irq), 32'h0);
    endtask
    task automatic report_and_stop;
        if (err_total == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        cyc(20);
        presetn <= 1'b1;
        t_regs();
        t_xmit();
        t_frame();
        t_wdog();
        report_and_stop();
    end
    initial begin
        #100000;
        err_total++;
        report_and_stop();
    end
endmodule
`default_nettype wire
